// *** logic/smbs_pkg.sv ***
// Shared constants, codes and state layout of the bus slave block
package smbs_pkg;

    // ================================================================
    // Addresses and commands
    localparam logic [6:0] ADDR_FLOAT = 7'h5c;
    localparam logic [6:0] ADDR_LOW   = 7'h58;
    localparam logic [6:0] ARA_ADDR   = 7'h0c;
    localparam logic [1:0] SEL_LOW    = 2'h0;
    localparam logic [1:0] SEL_FLOAT  = 2'h1;
    localparam logic [7:0] CMD_BLK_WR = 8'ha0;
    localparam logic [7:0] CMD_BLK_RD = 8'ha1;

    // ================================================================
    // Register map and fields
    localparam logic [7:0] REG_CONF0     = 8'h00;
    localparam logic [7:0] REG_CONF3     = 8'h03;
    localparam int         CNT_W         = 6;
    localparam int         CONF0_CNT_LSB = 0;
    localparam int         CONF3_SCL_BIT = 1;
    localparam int         CONF3_SDA_BIT = 2;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [5:0] BLK_MAX       = 6'h20;

    // ================================================================
    // Check byte
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // ================================================================
    // Timing
    localparam int unsigned CLK_HZ      = 50000000;
    localparam int unsigned TIMEOUT_MS  = 25;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int          TO_W        = 21;

    // ================================================================
    // Codes and state
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_MACK = 5'h10
    } smbs_state_t;

    typedef enum logic [2:0] {
        TXK_MEM = 3'h0,
        TXK_CNT = 3'h1,
        TXK_PEC = 3'h2,
        TXK_ARA = 3'h3,
        TXK_END = 3'h4
    } smbs_txk_t;

    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_CMD  = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;

    typedef struct packed {
        smbs_state_t      state;
        logic [2:0]       scl_s;
        logic [2:0]       sda_s;
        logic [1:0]       sel_s0;
        logic [1:0]       sel_s1;
        logic [1:0]       strap_cnt;
        logic [6:0]       own;
        logic             addr_ok;
        logic [3:0]       bit_cnt;
        logic [7:0]       shift;
        logic [7:0]       tx;
        logic [1:0]       idx;
        logic             is_rd;
        logic             ara;
        logic             blk_wr;
        logic             blk_rd;
        smbs_txk_t        nxt;
        logic [5:0]       remaining;
        logic [7:0]       ptr;
        logic [7:0]       crc;
        logic             mack_ok;
        logic             drv_lvl;
        logic             sda_oe_n;
        logic             alert_oe_n;
        logic             ara_done;
        logic [5:0]       cfg_cnt;
        logic             to_scl_en;
        logic             to_sda_en;
        logic [TO_W-1:0]  to_cnt;
        logic             we;
        logic [7:0]       waddr;
        logic [7:0]       wdata;
    } smbs_core_t;

    localparam smbs_core_t CORE_RESET = '{
        state: ST_IDLE, scl_s: 3'h7, sda_s: 3'h7, nxt: TXK_MEM,
        sda_oe_n: 1'b1, alert_oe_n: 1'b1, crc: CRC_INIT, default: '0};

endpackage : smbs_pkg

// *** logic/smbs_crc8.sv ***
// One-byte step of the packet check sequence
`timescale 1ns/1ps
`default_nettype none
module smbs_crc8 (
    // Running value
    input  wire logic [7:0] crc_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] crc_o
);
    function automatic logic [7:0] smbs_crc_step(input logic [7:0] c,
                                                 input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ smbs_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : smbs_crc_step

    assign crc_o = smbs_crc_step(crc_i, data_i);
endmodule : smbs_crc8
`default_nettype wire

// *** logic/smbs_regmem.sv ***
// Register space with registered read data
`timescale 1ns/1ps
`default_nettype none
module smbs_regmem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    input  wire logic          clk_en,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0]              rdata;
    } smbs_mem_t;

    smbs_mem_t s;
    smbs_mem_t n;

    always_comb begin
        n = s;
        n.rdata = s.mem[raddr];
        if (we) begin
            n.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else if (clk_en) begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
endmodule : smbs_regmem
`default_nettype wire

// *** logic/smbs_slave.sv ***
// Bus slave with block transfers, check byte, alert answer and timeout
`timescale 1ns/1ps
`default_nettype none
module smbs_slave #(
    parameter int unsigned TIMEOUT_CYCLES = smbs_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    // Bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    // Alert pin and its cause
    input  wire logic       alert_cond,
    output logic            alert_o,
    output logic            alert_oe_n,
    // Address strap
    input  wire logic [1:0] addr_sel
);
    smbs_pkg::smbs_core_t s;
    smbs_pkg::smbs_core_t n;

    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       rx_done;
    logic       own_hit;
    logic       ara_hit;
    logic       to_hit;
    logic       do_load;
    logic [5:0] cnt_clamp;
    logic [7:0] pick;
    logic [7:0] mem_rdata;
    logic [7:0] crc_byte;
    logic [7:0] crc_next;

    // ================================================================
    // Sub-blocks
    smbs_regmem #(.AW(8), .DW(8)) u_mem (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .we      (s.we),
        .waddr   (s.waddr),
        .wdata   (s.wdata),
        .raddr   (s.ptr),
        .rdata   (mem_rdata)
    );

    smbs_crc8 u_crc (
        .crc_i  (s.crc),
        .data_i (crc_byte),
        .crc_o  (crc_next)
    );

    // ================================================================
    // Decodes from registered state
    assign scl      = s.scl_s[1];
    assign sda      = s.sda_s[1];
    assign scl_rise = scl & ~s.scl_s[2];
    assign scl_fall = ~scl & s.scl_s[2];
    assign start_c  = scl & s.scl_s[2] & ~sda & s.sda_s[2];
    assign stop_c   = scl & s.scl_s[2] & sda & ~s.sda_s[2];
    assign rx_done  = (s.state == smbs_pkg::ST_RX) && scl_fall
                      && (s.bit_cnt == 4'h8);
    assign own_hit  = s.addr_ok && (s.shift[7:1] == s.own);
    assign ara_hit  = (s.shift[7:1] == smbs_pkg::ARA_ADDR) && s.shift[0]
                      && !s.alert_oe_n;
    assign cnt_clamp = (s.cfg_cnt > smbs_pkg::BLK_MAX) ? smbs_pkg::BLK_MAX
                                                       : s.cfg_cnt;
    // Only a line held low counts as stuck
    assign to_hit = (s.state != smbs_pkg::ST_IDLE)
        && (s.to_cnt >= smbs_pkg::TO_W'(TIMEOUT_CYCLES - 1))
        && ((s.to_scl_en && !scl) || (s.to_sda_en && !sda));
    assign crc_byte = (s.state == smbs_pkg::ST_RX) ? s.shift : pick;

    always_comb begin
        case (s.nxt)
            smbs_pkg::TXK_MEM: pick = mem_rdata;
            smbs_pkg::TXK_CNT: pick = {2'h0, cnt_clamp};
            smbs_pkg::TXK_PEC: pick = s.crc;
            smbs_pkg::TXK_ARA: pick = {s.own, 1'b0};
            default:           pick = 8'hff;
        endcase
    end

    // ================================================================
    // Next state
    always_comb begin
        n = s;
        do_load = 1'b0;
        n.we = 1'b0;
        n.scl_s = {s.scl_s[1:0], scl_i};
        n.sda_s = {s.sda_s[1:0], sda_i};
        n.sel_s0 = addr_sel;
        n.sel_s1 = s.sel_s0;

        // Strap is read once the synchroniser holds a settled value
        if (s.strap_cnt != 2'h3) begin
            n.strap_cnt = s.strap_cnt + 2'h1;
        end
        if (s.strap_cnt == 2'h2) begin
            n.addr_ok = (s.sel_s1 == smbs_pkg::SEL_LOW)
                        || (s.sel_s1 == smbs_pkg::SEL_FLOAT);
            n.own = (s.sel_s1 == smbs_pkg::SEL_LOW) ? smbs_pkg::ADDR_LOW
                                                    : smbs_pkg::ADDR_FLOAT;
        end

        // Shadow copies of the configuration that steer this logic
        if (s.we && (s.waddr == smbs_pkg::REG_CONF0)) begin
            n.cfg_cnt = s.wdata[smbs_pkg::CONF0_CNT_LSB +: smbs_pkg::CNT_W];
        end
        if (s.we && (s.waddr == smbs_pkg::REG_CONF3)) begin
            n.to_scl_en = s.wdata[smbs_pkg::CONF3_SCL_BIT];
            n.to_sda_en = s.wdata[smbs_pkg::CONF3_SDA_BIT];
        end

        if ((s.state == smbs_pkg::ST_IDLE) || (scl != s.scl_s[2])
            || (sda != s.sda_s[2])) begin
            n.to_cnt = '0;
        end else if (!(&s.to_cnt)) begin
            n.to_cnt = s.to_cnt + smbs_pkg::TO_W'(1);
        end

        // Alert stays latched until answered and the cause is gone
        if (s.alert_oe_n && alert_cond) begin
            n.alert_oe_n = 1'b0;
        end else if (!s.alert_oe_n && s.ara_done && !alert_cond) begin
            n.alert_oe_n = 1'b1;
            n.ara_done = 1'b0;
        end

        if (start_c) begin
            n.state = smbs_pkg::ST_RX;
            n.bit_cnt = 4'h0;
            n.idx = smbs_pkg::IDX_ADDR;
            n.sda_oe_n = 1'b1;
            n.blk_wr = 1'b0;
            // A repeated start keeps the check sum and block read
            if (s.state == smbs_pkg::ST_IDLE) begin
                n.crc = smbs_pkg::CRC_INIT;
                n.blk_rd = 1'b0;
            end
        end else if (stop_c || to_hit) begin
            n.state = smbs_pkg::ST_IDLE;
            n.sda_oe_n = 1'b1;
            n.blk_wr = 1'b0;
            n.blk_rd = 1'b0;
        end else begin
            case (s.state)
                smbs_pkg::ST_RX: begin
                    if (scl_rise && (s.bit_cnt != 4'h8)) begin
                        n.shift = {s.shift[6:0], sda};
                        n.bit_cnt = s.bit_cnt + 4'h1;
                    end
                    if (rx_done) begin
                        n.crc = crc_next;
                        n.state = smbs_pkg::ST_ACK;
                        n.sda_oe_n = 1'b0;
                        if (s.idx == smbs_pkg::IDX_ADDR) begin
                            n.idx = smbs_pkg::IDX_CMD;
                            n.is_rd = s.shift[0];
                            n.ara = ara_hit;
                            if (ara_hit) begin
                                n.nxt = smbs_pkg::TXK_ARA;
                            end else if (s.blk_rd) begin
                                n.nxt = smbs_pkg::TXK_CNT;
                            end else begin
                                n.nxt = smbs_pkg::TXK_MEM;
                            end
                            if (!(own_hit || ara_hit)) begin
                                n.state = smbs_pkg::ST_IDLE;
                                n.sda_oe_n = 1'b1;
                            end
                        end else if (s.idx == smbs_pkg::IDX_CMD) begin
                            n.idx = smbs_pkg::IDX_DATA;
                            if (s.shift == smbs_pkg::CMD_BLK_WR) begin
                                n.blk_wr = 1'b1;
                                n.remaining = cnt_clamp;
                            end else if (s.shift == smbs_pkg::CMD_BLK_RD) begin
                                n.blk_rd = 1'b1;
                            end else begin
                                n.ptr = s.shift;
                            end
                        end else if (s.blk_wr && (s.remaining == 6'h0)) begin
                            n.sda_oe_n = (s.shift != s.crc);
                            n.blk_wr = 1'b0;
                        end else begin
                            n.we = 1'b1;
                            n.waddr = s.ptr;
                            n.wdata = s.shift;
                            if (s.blk_wr) begin
                                n.ptr = s.ptr + 8'h01;
                                n.remaining = s.remaining - 6'h1;
                            end
                        end
                    end
                end
                smbs_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe_n = 1'b1;
                        n.bit_cnt = 4'h0;
                        n.state = smbs_pkg::ST_RX;
                        if (s.is_rd) begin
                            do_load = 1'b1;
                        end
                    end
                end
                smbs_pkg::ST_TX: begin
                    if (scl_rise && s.sda_oe_n && !sda) begin
                        n.state = smbs_pkg::ST_IDLE;
                        n.sda_oe_n = 1'b1;
                    end else if (scl_fall && (s.bit_cnt == 4'h7)) begin
                        n.sda_oe_n = 1'b1;
                        n.state = smbs_pkg::ST_MACK;
                        if (s.ara) begin
                            n.ara_done = 1'b1;
                        end
                    end else if (scl_fall) begin
                        n.tx = {s.tx[6:0], 1'b0};
                        n.sda_oe_n = s.tx[6];
                        n.bit_cnt = s.bit_cnt + 4'h1;
                    end
                end
                smbs_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        n.mack_ok = !sda;
                    end
                    if (scl_fall) begin
                        if (s.mack_ok) begin
                            do_load = 1'b1;
                        end else begin
                            n.state = smbs_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    n.sda_oe_n = 1'b1;
                end
            endcase
        end

        if (do_load) begin
            n.state = smbs_pkg::ST_TX;
            n.tx = pick;
            n.sda_oe_n = pick[7];
            n.bit_cnt = 4'h0;
            n.crc = crc_next;
            case (s.nxt)
                smbs_pkg::TXK_CNT: begin
                    n.remaining = cnt_clamp;
                    n.nxt = (cnt_clamp == 6'h0) ? smbs_pkg::TXK_PEC
                                                : smbs_pkg::TXK_MEM;
                end
                smbs_pkg::TXK_MEM: begin
                    if (s.blk_rd) begin
                        n.ptr = s.ptr + 8'h01;
                        n.remaining = s.remaining - 6'h1;
                        if (s.remaining == 6'h1) begin
                            n.nxt = smbs_pkg::TXK_PEC;
                        end
                    end
                end
                default: begin
                    n.nxt = smbs_pkg::TXK_END;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= smbs_pkg::CORE_RESET;
        end else if (clk_en) begin
            s <= n;
        end
    end

    assign sda_o      = s.drv_lvl;
    assign sda_oe_n   = s.sda_oe_n;
    assign alert_o    = s.drv_lvl;
    assign alert_oe_n = s.alert_oe_n;

    // ================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    addr_ack_a: assert property (
        clk_en && rx_done && (s.idx == smbs_pkg::IDX_ADDR) && own_hit
        && !start_c && !stop_c && !to_hit |=> !sda_oe_n)
        else $error("own address not acked");
    bwr_ack_a: assert property (
        clk_en && rx_done && s.blk_wr && (s.idx == smbs_pkg::IDX_DATA)
        && (s.remaining != 6'h0) && !to_hit |=> !sda_oe_n && s.we)
        else $error("block write byte not acked");
    pec_nack_a: assert property (
        clk_en && rx_done && s.blk_wr && (s.idx == smbs_pkg::IDX_DATA)
        && (s.remaining == 6'h0) && (s.shift != s.crc) && !to_hit
        |=> sda_oe_n)
        else $error("bad check byte acked");
    ptr_load_a: assert property (
        clk_en && rx_done && (s.idx == smbs_pkg::IDX_CMD) && !to_hit
        && (s.shift != smbs_pkg::CMD_BLK_WR)
        && (s.shift != smbs_pkg::CMD_BLK_RD) |=> s.ptr == $past(s.shift))
        else $error("pointer not loaded");
    cnt_max_a: assert property (
        clk_en && do_load && (s.nxt == smbs_pkg::TXK_CNT)
        |=> (s.tx <= 8'h20) && (s.remaining == s.tx[5:0]))
        else $error("byte count wrong");
    ara_own_a: assert property (
        clk_en && do_load && (s.nxt == smbs_pkg::TXK_ARA)
        |=> s.tx == {s.own, 1'b0})
        else $error("alert answer not own address");
    arb_lost_a: assert property (
        clk_en && (s.state == smbs_pkg::ST_TX) && scl_rise && s.sda_oe_n
        && !sda && !start_c && !stop_c |=> sda_oe_n && !s.ara_done
        ##0 (s.state == smbs_pkg::ST_IDLE))
        else $error("lost arbitration not released");
    alert_hold_a: assert property (
        !alert_oe_n && alert_cond |=> !alert_oe_n)
        else $error("alert released while cause present");
    timeout_a: assert property (
        clk_en && to_hit && !start_c |=> sda_oe_n
        && (s.state == smbs_pkg::ST_IDLE))
        else $error("stuck bus not released");
    ptr_inc_a: assert property (
        clk_en && do_load && s.blk_rd && (s.nxt == smbs_pkg::TXK_MEM)
        |=> s.ptr == $past(s.ptr) + 8'h01)
        else $error("pointer not advanced");

    bwr_done_c: cover property (
        rx_done && s.blk_wr && (s.remaining == 6'h0) && (s.shift == s.crc));
    brd_pec_c: cover property (do_load && (s.nxt == smbs_pkg::TXK_PEC));
    ara_c: cover property (do_load && (s.nxt == smbs_pkg::TXK_ARA));
    timeout_c: cover property (to_hit);
endmodule : smbs_slave
`default_nettype wire

// *** verification/smbs_host.sv ***
// Host model of the two-wire bus, open-drain levels with pull-ups
`timescale 1ns/1ps
`default_nettype none
module smbs_host (
    // Wire levels driven by the host, 1 means released
    output var logic scl,
    output var logic sda,
    // Resolved data wire
    input  wire logic sda_w
);
    // ==========================================
    // Bit timing: 160 ns per clock, data moves only while clock is low
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic bit_io(input logic b, output logic s);
        #20 sda = b;
        #60 scl = 1'b1;
        #60 s = sda_w;
        #20 scl = 1'b0;
    endtask : bit_io

    // Data released during a full low phase, so a repeated start
    // never shows a stop while the slave still drives its ack
    task automatic start();
        #20 sda = 1'b1;
        #60 scl = 1'b1;
        #60 sda = 1'b0;
        #80 scl = 1'b0;
    endtask : start

    task automatic stop();
        #20 sda = 1'b0;
        #60 scl = 1'b1;
        #60 sda = 1'b1;
        #20;
    endtask : stop

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : wbyte

    // Host acks count and data, nacks the last byte
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~mack, s);
    endtask : rbyte
endmodule : smbs_host
`default_nettype wire

// *** verification/smbs_slave_tb.sv ***
// Self-checking bench for the bus slave driven by the host model
`timescale 1ns/1ps
`default_nettype none
module smbs_slave_tb;
    localparam logic [7:0] AW = {smbs_pkg::ADDR_LOW, 1'b0};
    localparam logic [7:0] AR = {smbs_pkg::ADDR_LOW, 1'b1};
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       cond = 1'b0;
    logic       en = 1'b1;
    logic       sda_o, sda_oe_n, alert_o, alert_oe_n, scl, sda_h, a;
    wire logic  sda_w = sda_h & (sda_oe_n | sda_o);
    int         error_cnt = 0;
    int         check_count = 0;
    int         n;
    logic [7:0] m [256];
    logic [7:0] crc, b, p, e;

    always #10 ref_clk = ~ref_clk;

    smbs_slave #(.TIMEOUT_CYCLES(200)) smbs_slave_inst (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(en),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .alert_cond(cond), .alert_o(alert_o), .alert_oe_n(alert_oe_n),
        .addr_sel(smbs_pkg::SEL_LOW));
    smbs_host smbs_host_inst (.scl(scl), .sda(sda_h), .sda_w(sda_w));

    // ==========================================
    // Checking and expectation helpers
    task automatic chk(string nm, logic [7:0] ex, logic [7:0] g);
        check_count++;
        if (g !== ex) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", nm, ex, g);
        end
    endtask : chk

    function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
        c ^= d;
        for (int i = 0; i < 8; i++)
            c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    // ==========================================
    // Bus transfers; check byte runs from the start after idle
    task automatic st(logic clr);
        if (clr) crc = 8'h00;
        smbs_host_inst.start();
    endtask : st

    task automatic tx(logic [7:0] d);
        smbs_host_inst.wbyte(d, a);
        crc = crc8(crc, d);
    endtask : tx

    task automatic rx(logic mack);
        smbs_host_inst.rbyte(mack, b);
        crc = crc8(crc, b);
    endtask : rx

    task automatic wreg(logic [7:0] r, logic [7:0] d);
        st(1); tx(AW); chk("ack_adr", 1, a);
        tx(r); chk("ack_ptr", 1, a);
        tx(d); chk("ack_dat", 1, a);
        smbs_host_inst.stop();
        m[r] = d;
    endtask : wreg

    task automatic setp(logic [7:0] r);
        st(1); tx(AW); tx(r); chk("ack_snd", 1, a);
        smbs_host_inst.stop();
    endtask : setp

    task automatic rdp();
        st(1); tx(AR); chk("ack_rd", 1, a);
        rx(0);
        smbs_host_inst.stop();
    endtask : rdp

    initial begin
        #1_000_000;
        error_cnt++;
        test_done();
    end

    initial begin
        void'($urandom(32'ha3ce));
        repeat (12) @(negedge ref_clk);
        chk("oe_rst", 8'h1, {7'h0, sda_oe_n & alert_oe_n});
        chk("lvl_rst", 8'h0, {6'h0, sda_o, alert_o});
        resetn = 1'b1;
        repeat (8) @(negedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            p = 8'h10 + 8'($urandom_range(0, 127));
            wreg(p, 8'($urandom));
            setp(p);
            rdp();
            chk("rx_byte", m[p], b);
        end
        $display("test single done");
        for (int k = 0; k < 2; k++) begin
            n = k ? 32 : $urandom_range(1, 5);
            p = 8'h20 + 8'($urandom_range(0, 63));
            wreg(8'h00, 8'(n));
            for (int bad = 0; bad < 2; bad++) begin
                setp(p);
                st(1); tx(AW); tx(smbs_pkg::CMD_BLK_WR);
                chk("ack_bw", 1, a);
                for (int i = 0; i < n; i++) begin
                    m[p + 8'(i)] = 8'($urandom);
                    tx(m[p + 8'(i)]); chk("ack_bd", 1, a);
                end
                tx(crc ^ 8'(bad)); chk("pec_ack", 8'(!bad), a);
                smbs_host_inst.stop();
            end
            setp(p);
            st(1); tx(AW); tx(smbs_pkg::CMD_BLK_RD);
            chk("ack_br", 1, a);
            st(0); tx(AR); chk("ack_rs", 1, a);
            rx(1); chk("count", 8'(n), b);
            for (int i = 0; i < n; i++) begin
                rx(1); chk("blk_dat", m[p + 8'(i)], b);
            end
            e = crc;
            rx(0); chk("pec", e, b);
            smbs_host_inst.stop();
        end
        $display("test block done");
        st(1); tx({smbs_pkg::ADDR_FLOAT, 1'b0}); chk("nack", 0, a);
        smbs_host_inst.stop();
        // Frozen block must not take the cause in
        en = 1'b0;
        cond = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("freeze", 1, alert_oe_n);
        en = 1'b1;
        for (int k = 0; k < 2; k++) begin
            cond = 1'b1;
            repeat (3) @(negedge ref_clk);
            chk("alert_on", 0, alert_oe_n);
            // Second pass: cause gone before the answer
            cond = (k == 0);
            repeat (10) @(negedge ref_clk);
            chk("alert_keep", 0, alert_oe_n);
            if (k) begin
                st(1); tx(8'h19); smbs_host_inst.wbyte(8'h10, a);
                chk("arb_rel", 1, sda_oe_n);
                smbs_host_inst.stop();
                chk("arb_alert", 0, alert_oe_n);
            end
            st(1); tx(8'h19); chk("ack_ara", 1, a);
            rx(0); chk("ara", AW, b);
            smbs_host_inst.stop();
            repeat (4) @(negedge ref_clk);
            chk("alert", 8'(k), alert_oe_n);
            cond = 1'b0;
            repeat (10) @(negedge ref_clk);
            chk("alert_off", 1, alert_oe_n);
        end
        $display("test alert done");
        for (int i = 0; i < 3; i++) begin
            wreg(8'h03, 8'h1 << i);
            setp(8'h03); rdp(); chk("cfg3", m[3], b);
            setp(8'h08);
            st(1); tx(AR);
            repeat (20) @(negedge ref_clk);
            chk("drive", 0, sda_oe_n);
            chk("lvl", 8'h0, {6'h0, sda_o, alert_o});
            repeat (240) @(negedge ref_clk);
            chk("timeout", 8'(i > 0), sda_oe_n);
            rx(0);
            smbs_host_inst.stop();
        end
        $display("test timeout done");
        test_done();
    end
endmodule : smbs_slave_tb
`default_nettype wire
